/* rtl/pmfc_fault_charger_irq.sv */
// Fault, thermal and charger interrupt registers with coin cell charger control
`timescale 1ns/1ps
// Behaviour
// R01: Fault bank four shows live faults of three rails at bits 0, 1, 3.
// R02: Fault status bit 0 follows the die heat warning comparator.
// R03: Fault status bit 2 is high while any rail fault exists.
// R04: Fault mask bit 0 masks heat warning, bit 2 masks fault summary.
// R05: Fault mask register resets to 0x03.
// R06: Charger status register is read-only and resets to 0x00.
// R07: Charger status bit 1 shows input over-voltage.
// R08: Charger status bit 2 shows battery temperature out of window.
// R09: Charger status bit 5 sets on both presence edges; live level readable.
// R10: Charger mask bits 1, 2, 5; one masks; resets to 0x00.
// R11: Coin charger enable defaults on after reset.
// R12: Three-bit coin voltage select is writable while running.
// R13: Coin charging stops while the main supply is under-voltage.
// R14: Coin below 2.0 V is isolated and its conversion reads zero.
// R15: Host should keep coin charging enabled at all times.
// R16: Rail faults OR into one interrupt; unmasked, it raises the interrupt pin.
// R17: Over-temperature shutdown is debounced by one 32 kHz period.
// R18: Reserved bits ignore writes; they read zero except fault mask bit 1 and coin control bit 0, which read one.
module pmfc_fault_charger_irq (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial register port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // Comparator and fault inputs
   input wire pmfc_pkg::pmfc_sense_s sense_raw,
   input wire logic [9:0] coin_adc_raw,
   // Interrupt outputs
   output logic host_interrupt_pin,
   output logic first_level_fault_irq,
   output logic combined_rail_fault_irq,
   // Coin cell and thermal outputs
   output logic coin_charge_enable,
   output logic [2:0] coin_charge_voltage_sel,
   output logic coin_isolate,
   output logic [9:0] coin_adc_result,
   output logic thermal_shutdown_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   logic rst_a_q, rst_i;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_a_q <= 1'b0;
         rst_i <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_i <= rst_a_q;
      end
   end

   localparam int NS = $bits(pmfc_pkg::pmfc_sense_s);
   logic [NS-1:0] s1_q, s2_q, s3_q;
   pmfc_pkg::pmfc_sense_s sn;

   for (genvar i = 0; i < NS; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_i) begin
         if (!rst_i) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            sn[i] <= 1'b0;
         end else begin
            s1_q[i] <= sense_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               sn[i] <= s3_q[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial port
   pmfc_pkg::pmfc_req_s req;
   logic rd_pulse, wr_pulse;
   logic [7:0] rdata_q, rdata_d;

   pmfc_spi_slave u_spi (
      .clk(clk),
      .rst_n(rst_i),
      .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .spi_miso_oe_n(spi_miso_oe_n),
      .req(req),
      .rd_pulse(rd_pulse),
      .wr_pulse(wr_pulse),
      .rdata(rdata_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register file and interrupt logic
   logic [7:0] fmask_q, fmask_d, cmask_q, cmask_d, coin_q, coin_d;
   logic det_q, det_d, pres_q;
   logic [7:0] bank4, fstat, cstat, clive;
   logic any_fault, flvl_d, hirq_d;
   logic flvl_q, comb_q, hirq_q, cen_q, iso_q;
   logic [9:0] adc_q;
   logic pres_edge, stat_clr;

   always_comb begin
      bank4 = 8'h00;
      bank4[pmfc_pkg::B4_IMG25] = sn.img25; // R01
      bank4[pmfc_pkg::B4_IMG28] = sn.img28; // R01
      bank4[pmfc_pkg::B4_SDIO] = sn.sd_io; // R01
      any_fault = sn.img25 | sn.img28 | sn.sd_io | sn.other_rails; // R16
      fstat = 8'h00;
      fstat[pmfc_pkg::FS_HEAT] = sn.heat_warn; // R02
      fstat[pmfc_pkg::FS_SUMMARY] = any_fault; // R03
      clive = 8'h00;
      clive[pmfc_pkg::CS_OVP] = sn.ovp;
      clive[pmfc_pkg::CS_TEMP] = sn.batt_temp;
      clive[pmfc_pkg::CS_DET] = sn.presence; // R09
      cstat = 8'h00;
      cstat[pmfc_pkg::CS_OVP] = sn.ovp; // R07
      cstat[pmfc_pkg::CS_TEMP] = sn.batt_temp; // R08
      cstat[pmfc_pkg::CS_DET] = det_q; // R09
      pres_edge = sn.presence ^ pres_q; // R09
      stat_clr = rd_pulse & ~req.wr & (req.addr == pmfc_pkg::CHG_STAT_ADDR);
      det_d = pres_edge | (det_q & ~stat_clr); // R09
      fmask_d = fmask_q;
      cmask_d = cmask_q;
      coin_d = coin_q;
      if (wr_pulse) begin
         unique case (req.addr)
            pmfc_pkg::FAULT_MASK_ADDR: begin
               fmask_d = (req.wdata & pmfc_pkg::FAULT_MASK_WMASK)
                  | pmfc_pkg::FAULT_MASK_FIXED; // R04 R18
            end
            pmfc_pkg::CHG_MASK_ADDR: begin
               cmask_d = req.wdata & pmfc_pkg::CHG_MASK_WMASK; // R10 R18
            end
            pmfc_pkg::COIN_CTRL_ADDR: begin
               coin_d = (req.wdata & pmfc_pkg::COIN_CTRL_WMASK)
                  | pmfc_pkg::COIN_CTRL_FIXED; // R12 R18
            end
            default: begin
               coin_d = coin_q; // R06
            end
         endcase
      end
      rdata_d = rdata_q;
      if (rd_pulse) begin
         unique case (req.addr)
            pmfc_pkg::FAULT_STAT_ADDR: rdata_d = fstat;
            pmfc_pkg::FAULT_MASK_ADDR: rdata_d = fmask_q;
            pmfc_pkg::CHG_STAT_ADDR: rdata_d = cstat;
            pmfc_pkg::CHG_MASK_ADDR: rdata_d = cmask_q;
            pmfc_pkg::CHG_LIVE_ADDR: rdata_d = clive;
            pmfc_pkg::BANK4_ADDR: rdata_d = bank4;
            pmfc_pkg::COIN_CTRL_ADDR: rdata_d = coin_q;
            default: rdata_d = 8'h00; // R18
         endcase
      end
      flvl_d = (sn.heat_warn & ~fmask_q[pmfc_pkg::FS_HEAT])
         | (any_fault & ~fmask_q[pmfc_pkg::FS_SUMMARY]); // R04 R16
      hirq_d = flvl_d | (|(cstat & ~cmask_q)); // R10 R16
   end

   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         fmask_q <= pmfc_pkg::FAULT_MASK_RST; // R05
         cmask_q <= pmfc_pkg::CHG_MASK_RST; // R10
         coin_q <= pmfc_pkg::COIN_CTRL_RST; // R11
         det_q <= pmfc_pkg::CHG_STAT_RST[pmfc_pkg::CS_DET]; // R06
         pres_q <= 1'b0;
         rdata_q <= 8'h00;
         flvl_q <= 1'b0;
         comb_q <= 1'b0;
         hirq_q <= 1'b0;
      end else begin
         fmask_q <= fmask_d;
         cmask_q <= cmask_d;
         coin_q <= coin_d;
         det_q <= det_d;
         pres_q <= sn.presence;
         rdata_q <= rdata_d;
         flvl_q <= flvl_d;
         comb_q <= any_fault;
         hirq_q <= hirq_d;
      end
   end

   assign first_level_fault_irq = flvl_q;
   assign combined_rail_fault_irq = comb_q;
   assign host_interrupt_pin = hirq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Coin cell charger
   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         cen_q <= 1'b0;
         iso_q <= 1'b0;
         adc_q <= 10'h000;
      end else begin
         cen_q <= coin_q[pmfc_pkg::COIN_ON] & ~sn.main_uv; // R13
         iso_q <= sn.coin_low; // R14
         adc_q <= sn.coin_low ? 10'h000 : coin_adc_raw; // R14
      end
   end

   assign coin_charge_enable = cen_q;
   assign coin_charge_voltage_sel = coin_q[pmfc_pkg::COIN_VSEL_LSB +: 3]; // R12
   assign coin_isolate = iso_q;
   assign coin_adc_result = adc_q;

   ////////////////////////////////////////////////////////////////////////////
   // Over-temperature debounce on the slow tick
   localparam logic [10:0] TICK_LAST = 11'(pmfc_pkg::SLOW_TICK_CYCLES - 1);
   logic [10:0] div_q, div_d;
   logic tick, arm_q, arm_d, otsd_q, otsd_d;

   always_comb begin
      tick = (div_q == TICK_LAST);
      div_d = tick ? 11'd0 : div_q + 11'd1;
      arm_d = sn.overtemp & (arm_q | tick); // R17
      otsd_d = sn.overtemp & (otsd_q | (tick & arm_q)); // R17
   end

   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         div_q <= 11'd0;
         arm_q <= 1'b0;
         otsd_q <= 1'b0;
      end else begin
         div_q <= div_d;
         arm_q <= arm_d;
         otsd_q <= otsd_d;
      end
   end

   assign thermal_shutdown_req = otsd_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [11:0] ot_cnt_q;
   always_ff @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         ot_cnt_q <= 12'd0;
      end else if (!sn.overtemp) begin
         ot_cnt_q <= 12'd0;
      end else if (ot_cnt_q != 12'hfff) begin
         ot_cnt_q <= ot_cnt_q + 12'd1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_i);

   a_bank4_read: assert property (rd_pulse && !req.wr && req.addr == pmfc_pkg::BANK4_ADDR // R01
      |=> rdata_q == $past(bank4)) else $error("bank4 read mismatch");
   a_heat_flag_read: assert property (rd_pulse && req.addr == pmfc_pkg::FAULT_STAT_ADDR // R02
      |=> rdata_q[0] == $past(sn.heat_warn) && rdata_q[1] == 1'b0) else $error("heat flag");
   a_fault_summary: assert property (sn.img28 ##1 sn.img28 // R03
      |=> combined_rail_fault_irq) else $error("fault summary missing");
   a_first_level_mask: assert property (any_fault && !fmask_q[2] // R16
      |=> first_level_fault_irq && host_interrupt_pin) else $error("fault irq not raised");
   a_heat_masked: assert property (!any_fault && fmask_q[0] // R04
      |=> !first_level_fault_irq) else $error("masked heat flag leaked");
   a_mask_reset: assert property ($rose(rst_i) // R05
      |-> fmask_q == 8'h03 && cmask_q == 8'h00 && !det_q) else $error("mask reset");
   a_chg_stat_read: assert property (rd_pulse && req.addr == pmfc_pkg::CHG_STAT_ADDR // R07 R08
      |=> rdata_q[2:1] == $past({sn.batt_temp, sn.ovp})) else $error("charger status");
   a_det_set: assert property (pres_edge |=> det_q) else $error("presence edge lost"); // R09
   a_det_clear: assert property (stat_clr && !pres_edge // R09
      |=> !det_q) else $error("presence flag not cleared");
   a_cmask_write: assert property (wr_pulse && req.addr == pmfc_pkg::CHG_MASK_ADDR // R10
      |=> cmask_q == ($past(req.wdata) & 8'h26)) else $error("charger mask write");
   a_coin_default: assert property ($rose(rst_i) // R11
      |-> coin_q[1] && coin_q[4:2] == 3'b100) else $error("coin reset");
   a_coin_vsel: assert property (wr_pulse && req.addr == pmfc_pkg::COIN_CTRL_ADDR // R12
      |=> coin_charge_voltage_sel == $past(req.wdata[4:2])) else $error("coin vsel");
   a_coin_uv_stop: assert property (sn.main_uv // R13
      |=> !coin_charge_enable) else $error("coin charging under uv");
   a_coin_isolate: assert property (sn.coin_low // R14
      |=> coin_isolate && coin_adc_result == 10'h000) else $error("coin not isolated");
   a_otsd_debounce: assert property ($rose(thermal_shutdown_req) // R17
      |-> ot_cnt_q > 12'd1220) else $error("shutdown too early");
   a_resv_read: assert property (rd_pulse && req.addr == 9'h0d3 // R18
      |=> rdata_q == 8'h00) else $error("unmapped read not zero");

   c_presence_edge: cover property (pres_edge ##[1:40] stat_clr);
   c_irq_pin: cover property ($rose(host_interrupt_pin));
   c_shutdown: cover property ($rose(thermal_shutdown_req));
   c_coin_write: cover property (wr_pulse && req.addr == pmfc_pkg::COIN_CTRL_ADDR);

endmodule : pmfc_fault_charger_irq

/* rtl/pmfc_pkg.sv */
// Package: register map, field layout, reset values and timing for the fault/charger block
package pmfc_pkg;

   // Register offsets
   localparam logic [8:0] FAULT_STAT_ADDR = 9'h030;
   localparam logic [8:0] FAULT_MASK_ADDR = 9'h031;
   localparam logic [8:0] CHG_STAT_ADDR = 9'h0d0;
   localparam logic [8:0] CHG_MASK_ADDR = 9'h0d1;
   localparam logic [8:0] CHG_LIVE_ADDR = 9'h0d2;
   localparam logic [8:0] BANK4_ADDR = 9'h1cf;
   localparam logic [8:0] COIN_CTRL_ADDR = 9'h1d1;

   // Field positions
   localparam int B4_IMG25 = 0;
   localparam int B4_IMG28 = 1;
   localparam int B4_SDIO = 3;
   localparam int FS_HEAT = 0;
   localparam int FS_SUMMARY = 2;
   localparam int CS_OVP = 1;
   localparam int CS_TEMP = 2;
   localparam int CS_DET = 5;
   localparam int COIN_ON = 1;
   localparam int COIN_VSEL_LSB = 2;

   // Reset values, writable bits and fixed bits
   localparam logic [7:0] FAULT_MASK_RST = 8'h03;
   localparam logic [7:0] FAULT_MASK_WMASK = 8'h05;
   localparam logic [7:0] FAULT_MASK_FIXED = 8'h02;
   localparam logic [7:0] CHG_STAT_RST = 8'h00;
   localparam logic [7:0] CHG_MASK_RST = 8'h00;
   localparam logic [7:0] CHG_MASK_WMASK = 8'h26;
   localparam logic [7:0] COIN_CTRL_RST = 8'h13;
   localparam logic [7:0] COIN_CTRL_WMASK = 8'h1e;
   localparam logic [7:0] COIN_CTRL_FIXED = 8'h01;

   // Serial frame: write flag, 9-bit address, 6 pad bits, 8 data bits
   localparam logic [4:0] HDR_LAST = 5'd9;
   localparam logic [4:0] TX_LOAD = 5'd15;
   localparam logic [4:0] TX_SHIFT_FROM = 5'd17;
   localparam logic [4:0] FRAME_LAST = 5'd23;
   localparam logic [2:0] SPI_PIN_RST = 3'b010;

   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int SLOW_HZ = 32_768;
   localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_HZ;

   typedef struct packed {
      logic coin_low;
      logic main_uv;
      logic overtemp;
      logic heat_warn;
      logic other_rails;
      logic img25;
      logic img28;
      logic sd_io;
      logic presence;
      logic batt_temp;
      logic ovp;
   } pmfc_sense_s;

   typedef struct packed {
      logic wr;
      logic [8:0] addr;
      logic [7:0] wdata;
   } pmfc_req_s;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_SHIFT = 2'b01,
      SPI_DONE = 2'b10
   } pmfc_spi_state_e;

endpackage : pmfc_pkg

/* rtl/pmfc_spi_slave.sv */
// Serial register port: pin synchronisers, frame decode and read-data shifter
`timescale 1ns/1ps
module pmfc_spi_slave (
   // Clock and synchronised reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // Register side
   output pmfc_pkg::pmfc_req_s req,
   output logic rd_pulse,
   output logic wr_pulse,
   input wire logic [7:0] rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] raw;
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] flt_q;
   assign raw = {spi_sclk, spi_cs_n, spi_mosi};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i] <= pmfc_pkg::SPI_PIN_RST[i];
            s2_q[i] <= pmfc_pkg::SPI_PIN_RST[i];
            s3_q[i] <= pmfc_pkg::SPI_PIN_RST[i];
            flt_q[i] <= pmfc_pkg::SPI_PIN_RST[i];
         end else begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               flt_q[i] <= s3_q[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine
   pmfc_pkg::pmfc_spi_state_e state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [9:0] rx_q, rx_d;
   logic [9:0] hdr_q, hdr_d;
   logic [7:0] wdat_q, wdat_d;
   logic [7:0] tx_q, tx_d;
   logic sclk_q;
   logic rd_q, rd_d, wr_q, wr_d;
   logic rise, fall, sel;

   assign sel = ~flt_q[1];
   assign rise = flt_q[2] & ~sclk_q;
   assign fall = ~flt_q[2] & sclk_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      hdr_d = hdr_q;
      wdat_d = wdat_q;
      tx_d = tx_q;
      rd_d = 1'b0;
      wr_d = 1'b0;
      if (!sel) begin
         state_d = pmfc_pkg::SPI_IDLE;
         cnt_d = 5'd0;
      end else begin
         unique case (state_q)
            pmfc_pkg::SPI_IDLE: begin
               state_d = pmfc_pkg::SPI_SHIFT;
               cnt_d = 5'd0;
            end
            pmfc_pkg::SPI_SHIFT: begin
               if (rise) begin
                  rx_d = {rx_q[8:0], flt_q[0]};
                  cnt_d = cnt_q + 5'd1;
                  if (cnt_q == pmfc_pkg::HDR_LAST) begin
                     hdr_d = {rx_q[8:0], flt_q[0]};
                     rd_d = 1'b1;
                  end
                  if (cnt_q == pmfc_pkg::TX_LOAD) begin
                     tx_d = rdata;
                  end
                  if (cnt_q == pmfc_pkg::FRAME_LAST) begin
                     wdat_d = {rx_q[6:0], flt_q[0]};
                     wr_d = hdr_q[9];
                     state_d = pmfc_pkg::SPI_DONE;
                  end
               end else if (fall && cnt_q >= pmfc_pkg::TX_SHIFT_FROM) begin
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end
            pmfc_pkg::SPI_DONE: begin
               state_d = pmfc_pkg::SPI_DONE;
            end
            default: begin
               state_d = pmfc_pkg::SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pmfc_pkg::SPI_IDLE;
         cnt_q <= 5'd0;
         rx_q <= 10'h000;
         hdr_q <= 10'h000;
         wdat_q <= 8'h00;
         tx_q <= 8'h00;
         sclk_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         hdr_q <= hdr_d;
         wdat_q <= wdat_d;
         tx_q <= tx_d;
         sclk_q <= flt_q[2];
         rd_q <= rd_d;
         wr_q <= wr_d;
      end
   end

   assign req = '{wr: hdr_q[9], addr: hdr_q[8:0], wdata: wdat_q};
   assign rd_pulse = rd_q;
   assign wr_pulse = wr_q;
   assign spi_miso = tx_q[7];
   assign spi_miso_oe_n = ~sel;

endmodule : pmfc_spi_slave

/* tb/pmfc_spi_host.sv */
// Serial host model that drives frames into the register port
`timescale 1ns/1ps
module pmfc_spi_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe_n
);
   logic last_q;
   logic miso_seen;

   ////////////////////////////////////////////////////////////////////////////////
   // Released line shows the inverse of its last driven value
   always @(posedge clk) begin
      if (spi_miso_oe_n === 1'b0) begin
         last_q <= spi_miso;
      end
   end
   assign miso_seen = (spi_miso_oe_n === 1'b0) ? spi_miso : ~last_q;

   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      last_q = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One 24-bit frame; each half period lasts six clock cycles
   task automatic frame(input logic wr, input logic [8:0] addr, input logic [7:0] wd,
                        output logic [7:0] rd);
      logic [23:0] f;
      f = {wr, addr, 6'h00, wd};
      rd = 8'h00;
      @(negedge clk);
      spi_cs_n = 1'b0;
      repeat (6) @(negedge clk);
      for (int i = 23; i >= 0; i--) begin
         spi_mosi = f[i];
         repeat (6) @(negedge clk);
         if (i < 8) begin
            rd[i] = miso_seen;
         end
         spi_sclk = 1'b1;
         repeat (6) @(negedge clk);
         spi_sclk = 1'b0;
      end
      repeat (6) @(negedge clk);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      repeat (8) @(negedge clk);
   endtask : frame
endmodule : pmfc_spi_host

/* tb/pmfc_fault_charger_irq_test.sv */
// Register-level testbench for the fault and charger interrupt block
`timescale 1ns/1ps
module pmfc_fault_charger_irq_test;
   logic clk;
   logic rst_n;
   logic spi_sclk;
   logic spi_cs_n;
   logic spi_mosi;
   logic spi_miso;
   logic spi_miso_oe_n;
   pmfc_pkg::pmfc_sense_s sense;
   logic [9:0] coin_adc_raw;
   logic host_interrupt_pin;
   logic first_level_fault_irq;
   logic combined_rail_fault_irq;
   logic coin_charge_enable;
   logic [2:0] coin_charge_voltage_sel;
   logic coin_isolate;
   logic [9:0] coin_adc_result;
   logic thermal_shutdown_req;
   int failures;
   int cmp_count;
   int cycles;

   pmfc_fault_charger_irq pmfc_fault_charger_irq_i (
      .clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
      .sense_raw(sense), .coin_adc_raw(coin_adc_raw),
      .host_interrupt_pin(host_interrupt_pin), .first_level_fault_irq(first_level_fault_irq),
      .combined_rail_fault_irq(combined_rail_fault_irq),
      .coin_charge_enable(coin_charge_enable), .coin_charge_voltage_sel(coin_charge_voltage_sel),
      .coin_isolate(coin_isolate), .coin_adc_result(coin_adc_result),
      .thermal_shutdown_req(thermal_shutdown_req)
   );

   pmfc_spi_host pmfc_spi_host_i (
      .clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, timeout and verdict
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic close_out();
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, register access and settle helpers
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      logic [7:0] d;
      pmfc_spi_host_i.frame(1'b0, a, 8'h00, d);
      chk($sformatf("reg %h", a), {2'b00, d}, {2'b00, exp});
   endtask : rd

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      logic [7:0] junk;
      pmfc_spi_host_i.frame(1'b1, a, d, junk);
   endtask : wr

   task automatic settle();
      repeat (10) @(negedge clk);
   endtask : settle

   task automatic rails(input logic a, input logic b, input logic c, input logic o,
                        input logic [7:0] bank, input logic [7:0] stat);
      sense.img25 = a;
      sense.img28 = b;
      sense.sd_io = c;
      sense.other_rails = o;
      settle();
      rd(pmfc_pkg::BANK4_ADDR, bank);
      rd(pmfc_pkg::FAULT_STAT_ADDR, stat);
   endtask : rails

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      failures = 0;
      cmp_count = 0;
      cycles = 0;
      sense = '0;
      coin_adc_raw = 10'h2a5;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      settle();
      // Reset values and an unmapped place
      rd(pmfc_pkg::FAULT_MASK_ADDR, 8'h03);
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h00);
      rd(pmfc_pkg::CHG_MASK_ADDR, 8'h00);
      rd(pmfc_pkg::COIN_CTRL_ADDR, 8'h13);
      rd(9'h0d3, 8'h00);
      chk("coin_en", {9'h000, coin_charge_enable}, 10'h001);
      chk("coin_vsel", {7'h00, coin_charge_voltage_sel}, 10'h004);
      // Bank four flags and summary
      rails(1'b1, 1'b0, 1'b0, 1'b0, 8'h01, 8'h04);
      rails(1'b0, 1'b1, 1'b0, 1'b0, 8'h02, 8'h04);
      rails(1'b0, 1'b0, 1'b1, 1'b0, 8'h08, 8'h04);
      rails(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h04);
      rails(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      // Read-only places ignore writes
      wr(pmfc_pkg::BANK4_ADDR, 8'hff);
      rd(pmfc_pkg::BANK4_ADDR, 8'h00);
      wr(pmfc_pkg::CHG_STAT_ADDR, 8'hff);
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h00);
      // Heat warning and fault mask
      sense.heat_warn = 1'b1;
      settle();
      rd(pmfc_pkg::FAULT_STAT_ADDR, 8'h01);
      chk("fault_irq masked", {9'h000, first_level_fault_irq}, 10'h000);
      wr(pmfc_pkg::FAULT_MASK_ADDR, 8'h00);
      rd(pmfc_pkg::FAULT_MASK_ADDR, 8'h02);
      chk("fault_irq heat", {9'h000, first_level_fault_irq}, 10'h001);
      chk("pin heat", {9'h000, host_interrupt_pin}, 10'h001);
      sense.heat_warn = 1'b0;
      sense.sd_io = 1'b1;
      settle();
      chk("fault_irq rail", {9'h000, first_level_fault_irq}, 10'h001);
      chk("combined", {9'h000, combined_rail_fault_irq}, 10'h001);
      wr(pmfc_pkg::FAULT_MASK_ADDR, 8'hff);
      rd(pmfc_pkg::FAULT_MASK_ADDR, 8'h07);
      chk("fault_irq rail masked", {9'h000, first_level_fault_irq}, 10'h000);
      sense.sd_io = 1'b0;
      settle();
      chk("combined off", {9'h000, combined_rail_fault_irq}, 10'h000);
      // Charger status levels and presence edges
      sense.ovp = 1'b1;
      sense.batt_temp = 1'b1;
      settle();
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h06);
      wr(pmfc_pkg::CHG_MASK_ADDR, 8'hff);
      rd(pmfc_pkg::CHG_MASK_ADDR, 8'h26);
      chk("pin chg masked", {9'h000, host_interrupt_pin}, 10'h000);
      wr(pmfc_pkg::CHG_MASK_ADDR, 8'h00);
      settle();
      chk("pin chg", {9'h000, host_interrupt_pin}, 10'h001);
      sense.ovp = 1'b0;
      sense.batt_temp = 1'b0;
      sense.presence = 1'b1;
      settle();
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h20);
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h00);
      rd(pmfc_pkg::CHG_LIVE_ADDR, 8'h20);
      chk("pin clear", {9'h000, host_interrupt_pin}, 10'h000);
      sense.presence = 1'b0;
      settle();
      rd(pmfc_pkg::CHG_STAT_ADDR, 8'h20);
      rd(pmfc_pkg::CHG_LIVE_ADDR, 8'h00);
      // Coin charger control, supply drop and isolation
      wr(pmfc_pkg::COIN_CTRL_ADDR, 8'hea);
      rd(pmfc_pkg::COIN_CTRL_ADDR, 8'h0b);
      chk("coin_vsel new", {7'h00, coin_charge_voltage_sel}, 10'h002);
      sense.main_uv = 1'b1;
      settle();
      chk("coin_en uv", {9'h000, coin_charge_enable}, 10'h000);
      sense.main_uv = 1'b0;
      settle();
      chk("coin_en back", {9'h000, coin_charge_enable}, 10'h001);
      chk("coin_adc", coin_adc_result, 10'h2a5);
      sense.coin_low = 1'b1;
      settle();
      chk("coin_iso", {9'h000, coin_isolate}, 10'h001);
      chk("coin_adc low", coin_adc_result, 10'h000);
      sense.coin_low = 1'b0;
      // Over-temperature debounce
      sense.overtemp = 1'b1;
      repeat (1200) @(negedge clk);
      chk("shutdown early", {9'h000, thermal_shutdown_req}, 10'h000);
      for (int i = 0; i < 2600 && thermal_shutdown_req !== 1'b1; i++) begin
         @(negedge clk);
      end
      chk("shutdown", {9'h000, thermal_shutdown_req}, 10'h001);
      sense.overtemp = 1'b0;
      settle();
      chk("shutdown off", {9'h000, thermal_shutdown_req}, 10'h000);
      close_out();
   end
endmodule : pmfc_fault_charger_irq_test
